// >>> logic/dpfd_defines.svh
/*
 Offsets, field positions, reset value, window limits and timing counts
 for the fine phase-loss detector. Assumes a 100 MHz core clock.
*/
`ifndef DPFD_DEFINES_SVH
`define DPFD_DEFINES_SVH

`define DPFD_CFG_ADDR 8'h73
`define DPFD_CFG_RESET 8'ha2
`define DPFD_CFG_USED_MASK 8'he7

`define DPFD_BIT_FINE_EN 7
`define DPFD_BIT_INACT 6
`define DPFD_BIT_NARROW 5
`define DPFD_WIN_MSB 2
`define DPFD_WIN_LSB 0

// Window half-widths in phase-error units, one per code 1 to 7; code 0 reuses the first
`define DPFD_WIN_LIM_1 12'h040
`define DPFD_WIN_LIM_2 12'h080
`define DPFD_WIN_LIM_3 12'h0c0
`define DPFD_WIN_LIM_4 12'h100
`define DPFD_WIN_LIM_5 12'h180
`define DPFD_WIN_LIM_6 12'h200
`define DPFD_WIN_LIM_7 12'h300

`define DPFD_CLK_MHZ 100
`define DPFD_CYC_PER_MS (`DPFD_CLK_MHZ * 1000)
`define DPFD_LOCK_QUAL_MS 1000
`define DPFD_LOCK_QUAL_CYC (`DPFD_LOCK_QUAL_MS * `DPFD_CYC_PER_MS)

`endif

// >>> logic/dpfd_pkg.sv
/*
 Types of the fine phase-loss detector: register request, configuration
 layout and qualification states. Needs no other file.
*/
package dpfd_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dpfd_reg_req_t;

    typedef struct packed {
        logic fine_en;
        logic inact_loss;
        logic narrow_en;
        logic [1:0] unused;
        logic [2:0] win_code;
    } dpfd_cfg_t;

    typedef enum logic [1:0] {
        DPFD_HUNT = 2'b00,
        DPFD_QUAL = 2'b01,
        DPFD_LOCKED = 2'b10
    } dpfd_state_t;

endpackage

// >>> logic/dpfd_top.sv
/*
 Fine phase-lock and phase-loss detector with its configuration register.

 Holds:
 - the single fine-window configuration register, written and read through
   a simple strobe port with one cycle of read latency
 - the window limit decode of the three-bit window code
 - the loss decision, combining the fine window trip, the optional
   inactivity trip and the loss flag of the other detectors
 - the lock qualification machine, which needs an unbroken run of
   in-window cycles before lock is shown
 - one-cycle event pulses on lock and on the rise of loss

 Assumes:
 - the phase error magnitude, reference activity and the loss flag
   of the other detectors are synchronous to core_clk
 - the phase error is an unsigned magnitude already folded about zero
 - LOCK_QUAL_CYC is at least 1 and fits the 28-bit qualification counter
 - only one register address is mapped; all other reads return zero
*/
`timescale 1ns/1ps
`include "dpfd_defines.svh"

module dpfd_top #(
    parameter int unsigned LOCK_QUAL_CYC = `DPFD_LOCK_QUAL_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire dpfd_pkg::dpfd_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [11:0] phase_err_mag,
    input wire logic ref_active,
    input wire logic other_loss,
    output logic phase_locked,
    output logic phase_loss,
    output logic lock_event,
    output logic loss_event,
    output dpfd_pkg::dpfd_cfg_t cfg_out
);

    localparam logic [27:0] QUAL_LAST = 28'(LOCK_QUAL_CYC - 1);

    // Register port
    // Read data is registered so the answer lines never glitch;
    // a write and a read in one cycle returns the old value.

    dpfd_pkg::dpfd_cfg_t cfg_reg;
    dpfd_pkg::dpfd_cfg_t cfg_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic cfg_hit;

    assign cfg_hit = (reg_req.addr == `DPFD_CFG_ADDR);

    always_comb begin
        cfg_next = cfg_reg;
        rdata_next = rdata_reg;
        rvalid_next = reg_req.rd;
        if (reg_req.wr && cfg_hit) begin
            // Unused bits are dropped on write so they always read as zero
            cfg_next = dpfd_pkg::dpfd_cfg_t'(reg_req.wdata & `DPFD_CFG_USED_MASK);
        end
        if (reg_req.rd) begin
            rdata_next = cfg_hit ? (cfg_reg & `DPFD_CFG_USED_MASK) : 8'h00;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= dpfd_pkg::dpfd_cfg_t'(`DPFD_CFG_RESET);
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign cfg_out = cfg_reg;

    // Window selection
    // The limit follows the register at once, so a window change
    // takes effect on the very next comparison with no settling time.

    logic [11:0] win_limit;

    always_comb begin
        unique case (cfg_reg.win_code)
            3'h0: win_limit = `DPFD_WIN_LIM_1;
            3'h1: win_limit = `DPFD_WIN_LIM_1;
            3'h2: win_limit = `DPFD_WIN_LIM_2;
            3'h3: win_limit = `DPFD_WIN_LIM_3;
            3'h4: win_limit = `DPFD_WIN_LIM_4;
            3'h5: win_limit = `DPFD_WIN_LIM_5;
            3'h6: win_limit = `DPFD_WIN_LIM_6;
            3'h7: win_limit = `DPFD_WIN_LIM_7;
        endcase
    end
    // Code 000 is unsupported; it falls back to the smallest window

    // Equal to the limit still counts as inside the window
    logic out_of_win;
    logic fine_trip;
    logic silent_trip;
    logic silent_hold;
    logic loss_now;

    assign out_of_win = (phase_err_mag > win_limit);
    assign fine_trip = cfg_reg.fine_en && out_of_win;
    assign silent_trip = cfg_reg.inact_loss && !ref_active;
    // Silence with the trigger off freezes qualification instead of losing lock
    assign silent_hold = !cfg_reg.inact_loss && !ref_active;
    assign loss_now = fine_trip || silent_trip || other_loss;

    // Lock qualification
    // Lock needs an unbroken run of in-window cycles; loss needs none.
    // The asymmetry keeps lock slow to claim and quick to give up.

    dpfd_pkg::dpfd_state_t state_reg;
    dpfd_pkg::dpfd_state_t state_next;

    logic [27:0] qual_cnt_reg;
    logic [27:0] qual_cnt_next;

    logic loss_reg;
    logic loss_next;

    logic lock_ev_reg;
    logic lock_ev_next;

    logic loss_ev_reg;
    logic loss_ev_next;

    always_comb begin
        // Defaults hold state and keep both event pulses low
        state_next = state_reg;
        qual_cnt_next = qual_cnt_reg;
        lock_ev_next = 1'b0;
        loss_ev_next = 1'b0;
        loss_next = loss_now;
        if (loss_now && !loss_reg) begin
            loss_ev_next = 1'b1;
        end
        if (loss_now) begin
            // Loss wins over any qualification in progress
            state_next = dpfd_pkg::DPFD_HUNT;
            qual_cnt_next = 28'h0000000;
        end else if (silent_hold) begin
            qual_cnt_next = qual_cnt_reg;
        end else begin
            unique case (state_reg)
                dpfd_pkg::DPFD_HUNT: begin
                    if (!out_of_win) begin
                        state_next = dpfd_pkg::DPFD_QUAL;
                        qual_cnt_next = 28'h0000000;
                    end
                end
                dpfd_pkg::DPFD_QUAL: begin
                    if (out_of_win) begin
                        // Any excursion restarts the sustained-window timer
                        state_next = dpfd_pkg::DPFD_HUNT;
                        qual_cnt_next = 28'h0000000;
                    end else if (qual_cnt_reg == QUAL_LAST) begin
                        state_next = dpfd_pkg::DPFD_LOCKED;
                        lock_ev_next = 1'b1;
                    end else begin
                        qual_cnt_next = qual_cnt_reg + 28'h0000001;
                    end
                end
                dpfd_pkg::DPFD_LOCKED: begin
                    // Fine check off: window excursions leave lock untouched
                    state_next = dpfd_pkg::DPFD_LOCKED;
                end
                default: begin
                    state_next = dpfd_pkg::DPFD_HUNT;
                    qual_cnt_next = 28'h0000000;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= dpfd_pkg::DPFD_HUNT;
            qual_cnt_reg <= 28'h0000000;
            loss_reg <= 1'b0;
            lock_ev_reg <= 1'b0;
            loss_ev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            qual_cnt_reg <= qual_cnt_next;
            loss_reg <= loss_next;
            lock_ev_reg <= lock_ev_next;
            loss_ev_reg <= loss_ev_next;
        end
    end

    // Lock is decoded from the state register, loss and events are
    // registered, so every status output is free of glitches.

    assign phase_locked = (state_reg == dpfd_pkg::DPFD_LOCKED);
    assign phase_loss = loss_reg;
    assign lock_event = lock_ev_reg;
    assign loss_event = loss_ev_reg;

endmodule

// >>> verif/dpfd_ref_src.sv
/* Reference source ahead of the phase detector.
 Set by the bench at the falling clock edge. */
`timescale 1ns/1ps
module dpfd_ref_src (
    input wire logic [11:0] err_set,
    input wire logic silent,
    output logic [11:0] phase_err_mag,
    output logic ref_active
);
    initial phase_err_mag = 12'h000;
    // No edges while silent, so the last measurement stays
    always @(err_set or silent) begin
        if (!silent) begin
            phase_err_mag = err_set;
        end
    end
    assign ref_active = !silent;
endmodule

// >>> verif/dpfd_top_assertions.sv
/* Port checker of the fine phase-loss detector.
 Bound to dpfd_top from the bench; assumes one clock. */
`timescale 1ns/1ps
`include "dpfd_defines.svh"
module dpfd_top_assertions #(
    parameter int unsigned LOCK_QUAL_CYC = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire dpfd_pkg::dpfd_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [11:0] phase_err_mag,
    input wire logic ref_active,
    input wire logic other_loss,
    input wire logic phase_locked,
    input wire logic phase_loss,
    input wire logic lock_event,
    input wire logic loss_event,
    input wire dpfd_pkg::dpfd_cfg_t cfg_out
);
    localparam logic [11:0] LIMS [8] = '{`DPFD_WIN_LIM_1, `DPFD_WIN_LIM_1, `DPFD_WIN_LIM_2, `DPFD_WIN_LIM_3,
        `DPFD_WIN_LIM_4, `DPFD_WIN_LIM_5, `DPFD_WIN_LIM_6, `DPFD_WIN_LIM_7};
    logic [31:0] run_reg, run_next;
    logic out_win;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Saturates just past the qualification so a lock rise can be judged
    always_comb begin
        out_win = phase_err_mag > LIMS[cfg_out.win_code];
        run_next = run_reg;
        if (out_win || other_loss || (cfg_out.inact_loss && !ref_active)) begin
            run_next = 32'h0;
        end else if (ref_active && run_reg <= LOCK_QUAL_CYC) begin
            run_next = run_reg + 32'h1;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_reg <= 32'h0;
        end else begin
            run_reg <= run_next;
        end
    end
    sequence s_cfg_read;
        reg_req.rd && reg_req.addr == `DPFD_CFG_ADDR;
    endsequence
    a_cfg_reset: assert property ($rose(rst_n) |-> cfg_out == `DPFD_CFG_RESET)
        else $error("cfg_out not at reset value");
    a_fine_quiet: assert property (!cfg_out.fine_en && !other_loss && (ref_active || !cfg_out.inact_loss)
        |=> !phase_loss) else $error("loss raised with fine check off");
    a_fine_loss: assert property (cfg_out.fine_en && out_win |=> phase_loss && !phase_locked)
        else $error("out of window without loss");
    a_inact_loss: assert property (cfg_out.inact_loss && !ref_active |=> phase_loss)
        else $error("silent reference without loss");
    a_silent_hold: assert property (phase_locked && !ref_active && !cfg_out.inact_loss && !other_loss
        && !out_win |=> phase_locked) else $error("lock dropped on silence");
    a_loss_pulse: assert property (loss_event == $rose(phase_loss))
        else $error("loss event not on loss rise");
    a_lock_qual: assert property ($rose(phase_locked) |-> lock_event && run_reg > LOCK_QUAL_CYC)
        else $error("lock without full qualification");
    a_read_back: assert property (s_cfg_read |=> reg_rvalid && reg_rdata == $past(cfg_out)
        && reg_rdata[4:3] == 2'b00) else $error("bad read back");
endmodule

// >>> verif/dpfd_top_bench.sv
/* Self-checking bench of the fine phase-loss detector, short lock count.
 Needs the design, its checker and the reference source. */
`timescale 1ns/1ps
`include "dpfd_defines.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; $display("[ERR] %0t %h %h", $time, g, e); end end
module dpfd_top_bench;
    localparam int unsigned QUAL = 8;
    localparam logic [11:0] LIMS [8] = '{`DPFD_WIN_LIM_1, `DPFD_WIN_LIM_1, `DPFD_WIN_LIM_2, `DPFD_WIN_LIM_3,
        `DPFD_WIN_LIM_4, `DPFD_WIN_LIM_5, `DPFD_WIN_LIM_6, `DPFD_WIN_LIM_7};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic silent = 1'b0;
    logic other_loss = 1'b0;
    logic [11:0] err_set = 12'h000;
    logic [31:0] seed = 32'h526875d7;
    dpfd_pkg::dpfd_reg_req_t reg_req = '0;
    dpfd_pkg::dpfd_cfg_t cfg_out;
    logic [7:0] reg_rdata;
    logic [11:0] phase_err_mag;
    logic [8:0] rd_seen = 9'h000;
    logic reg_rvalid, ref_active, phase_locked, phase_loss, lock_event, loss_event;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;
    initial forever #5 core_clk = ~core_clk;
    dpfd_ref_src i_dpfd_ref_src (.err_set, .silent, .phase_err_mag, .ref_active);
    dpfd_top #(.LOCK_QUAL_CYC(QUAL)) i_dpfd_top (.core_clk, .rst_n, .reg_req, .reg_rdata, .reg_rvalid,
        .phase_err_mag, .ref_active, .other_loss, .phase_locked, .phase_loss, .lock_event, .loss_event, .cfg_out);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic close_out;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic step(input logic [11:0] e, input logic s);
        err_set = e;
        silent = s;
        @(negedge core_clk);
    endtask
    task automatic cfg_io(input logic w, input logic [7:0] a, input logic [7:0] d);
        reg_req = '{w, !w, a, d};
        @(negedge core_clk);
        rd_seen = {reg_rvalid, reg_rdata};
        reg_req = '0;
        // Idle cycle so the next strobe is a fresh pulse
        @(negedge core_clk);
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 2000) begin
            failures++;
            close_out;
        end
    end
    initial begin
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        foreach (LIMS[c]) begin
            cfg_io(1'b0, c == 0 ? 8'h73 : 8'h80 + 8'(c), 8'h00);
            `CHK(rd_seen, {1'b1, c == 0 ? 8'ha2 : 8'h00})
        end
        cfg_io(1'b1, 8'h73, 8'hff);
        `CHK(cfg_out, 8'he7)
        cfg_io(1'b0, 8'h73, 8'h00);
        `CHK(rd_seen, 9'h1e7)
        for (int c = 1; c < 8; c++) begin
            cfg_io(1'b1, 8'h73, {5'b10100, 3'(c)});
            step(LIMS[c] + 12'h001, 1'b0);
            `CHK(phase_loss, 1'b1)
            step(12'(rnd() % (LIMS[c] + 32'h1)), 1'b0);
            `CHK(phase_loss, 1'b0)
        end
        cfg_io(1'b1, 8'h73, 8'h22);
        step(12'hfff, 1'b0);
        `CHK(phase_loss, 1'b0)
        step(12'h010, 1'b1);
        `CHK(phase_loss, 1'b0)
        cfg_io(1'b1, 8'h73, 8'h62);
        @(negedge core_clk);
        `CHK(phase_loss, 1'b1)
        other_loss = 1'b1;
        step(12'h010, 1'b0);
        `CHK(phase_loss, 1'b1)
        other_loss = 1'b0;
        cfg_io(1'b1, 8'h73, 8'ha2);
        step(12'hfff, 1'b0);
        `CHK({phase_loss, loss_event}, 2'b11)
        err_set = 12'(rnd() % 32'h81);
        n = 0;
        while (phase_locked !== 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        `CHK({n, lock_event}, {QUAL + 1, 1'b1})
        step(12'h081, 1'b0);
        `CHK({phase_loss, phase_locked}, 2'b10)
        close_out;
    end
endmodule
bind dpfd_top dpfd_top_assertions #(.LOCK_QUAL_CYC(LOCK_QUAL_CYC)) i_dpfd_top_assertions (.core_clk, .rst_n,
    .reg_req, .reg_rdata, .reg_rvalid, .phase_err_mag, .ref_active, .other_loss, .phase_locked, .phase_loss,
    .lock_event, .loss_event, .cfg_out);
